// [logic/lcdsd_pkg.sv]
// constants for the segment display driver control block
// assumes a 32-bit apb master and one 50 MHz clock for all logic
package lcdsd_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_SEG_LOW      = 10'h00e5;
    localparam logic [9:0] IDX_SEG_MID_LOW  = 10'h00e6;
    localparam logic [9:0] IDX_SEG_MID_HIGH = 10'h00e7;
    localparam logic [9:0] IDX_SEG_HIGH     = 10'h00ee;
    localparam logic [9:0] IDX_CONTROL      = 10'h00f9;
    localparam logic [9:0] IDX_CLOCK_CFG    = 10'h00fa;
    localparam logic [9:0] IDX_DATA_INDEX   = 10'h00fb;
    localparam logic [9:0] IDX_DATA_PORT    = 10'h00fc;

    // control register fields
    localparam int CTL_ON_BIT     = 7;
    localparam int CTL_TRIM_BIT   = 6;
    localparam int CTL_BIAS_BIT   = 4;
    localparam int CTL_DUTY_LSB   = 2;
    localparam int CTL_LADDER_LSB = 0;
    // clock config fields
    localparam int CLK_SRC_LSB    = 4;
    localparam int CLK_DIV_LSB    = 0;

    localparam logic [7:0] REG_RESET = 8'h00;

    // duty codes
    localparam logic [1:0] DUTY_QUARTER = 2'h0;
    localparam logic [1:0] DUTY_THIRD   = 2'h1;
    localparam logic [1:0] DUTY_SIXTH   = 2'h2;
    // ladder codes: 150k, 300k, 600k
    localparam logic [1:0] LADDER_150K  = 2'h0;
    localparam logic [1:0] LADDER_300K  = 2'h1;
    localparam logic [1:0] LADDER_600K  = 2'h2;
    // clock source codes
    localparam logic [1:0] SRC_SYSTEM   = 2'h0;
    localparam logic [1:0] SRC_CRYSTAL  = 2'h1;
    localparam logic [1:0] SRC_RC       = 2'h2;
    // highest valid divider code (divide by 32)
    localparam logic [2:0] DIV_MAX_CODE = 3'h5;

    // prescaler lengths in source cycles
    localparam int          SYS_PRESCALE = 4096;
    localparam int          LS_PRESCALE  = 16;
    localparam logic [11:0] SYS_PRE_LAST = 12'(SYS_PRESCALE - 1);
    localparam logic [11:0] LS_PRE_LAST  = 12'(LS_PRESCALE - 1);

    // segments lost to the crystal pins
    localparam int SEG_XTAL_A = 29;
    localparam int SEG_XTAL_B = 30;

endpackage : lcdsd_pkg

// [logic/lcdsd_top.sv]
// segment display driver control: registers, display memory, common sequencing
// assumes apb master on mclk; crystal and rc clocks arrive as synchronous levels
// Summary of operation
// (RULE1) driver off: pins stay general io; on: commons and enabled segments drive
// (RULE2) bias bit clear selects one-third bias, set selects one-half bias
// (RULE3) duty 00 quarter, 01 third, 10 sixth; 11 is invalid and drives nothing
// (RULE4) third duty uses only commons 0 to 2; common 3 returns to io
// (RULE5) sixth duty turns segment pins 0 and 1 into commons 4 and 5
// (RULE6) ladder code picks 150k, 300k or 600k; code 11 reserved
// (RULE7) clock source: system/4096, crystal/16, rc/16; code 11 reserved
// (RULE8) low-speed sources keep the display running in power-down
// (RULE9) crystal source removes segments 29 and 30
// (RULE10) divider codes 0 to 5 divide by 1 to 32; others reserved
// (RULE11) five-bit index picks the display register behind the data port
// (RULE12) six data bits per register; 1 darkens, 0 clears the pixel
// (RULE13) software sets the index before each data port access
// (RULE14) 32 enable bits in four registers gate each segment pin
// (RULE15) enabled segment reads port data as 0; writes still reach latch
// (RULE16) software makes used pins input-only before enabling the driver
// (RULE17) software configures everything first and sets driver on last
// (RULE18) software starts the crystal before relying on it
// (RULE19) software picks a frame rate near 30 to 100 Hz
// (RULE20) 32 display registers, one per segment pin across commons
// (RULE21) commons are activated in turn, as many as the duty uses
// (RULE22) software leaves duty and bias alone while the driver is on
// (RULE23) reserved register bits read zero and ignore writes
//
// Our own choice: the APB register port.
`timescale 1ns/1ps

// bus side
// setup, then two access cycles
// pready rises in the second one
// read data and error captured first
// a write lands on the pready edge
// ready lasts one cycle, so a held
// request is answered every other cycle
// only the low byte lane is used
// unmapped index: pslverr and zero
//
// register side
// all fields clear on srst
// reserved bits are not stored
// so they always read zero
// data port uses the current index
// a data access leaves the index
// software reloads it each time
//
// display memory
// 32 words of six bits
// one word per segment pin
// bit c of word s: segment s, common c
// bits above the duty stay unseen
// kept in the state struct for one
// register process; costs a wide copy
//
// clock chain
// slow clocks come in as levels
// their rising edges are counted
// edge flops reset low, the idle
// level, so no false edge after reset
// system source stops in power_down
// slow sources run through power_down
// prescale 4096 or 16, then 2^div
// reserved source or divider: frozen
// counters restart at or past last,
// so a new setting never waits a wrap
//
// common sequencer
// each display tick flips drive_phase
// two halves make one common slot
// index moves on the second half
// wraps after common 3, 2 or 5
// off or bad duty parks it at 0
// duty change while on is unguarded
// it wraps at the new last common
//
// pin function
// com_pin_lcd: commons in use
// com_select: one-hot active common
// seg_pin_lcd: segments with waveforms
// sixth duty takes segments 0 and 1
// crystal takes segments 29 and 30
// seg_dark: pixels of active common
// bias levels and ladder live outside
// only field values are handed over
//
// port read path
// enabled segments read zero when on
// mask ignores duty and crystal
// exclusions, like the enable bits
// io output latch is outside
//
// timing
// every output is a state flop
// pin outputs lag fields by a clock
// inputs are synchronous to mclk
// no interrupt, no clock gating
//
// limitations
// slow clocks must stay at or below mclk/2
// faster ones lose edges silently
// first frame after a change may be short
// SEGS below 31 breaks crystal masking
//
// expected software order
// used pins input-only first
// trim, duty, bias, clock next
// segment enables after that
// driver on as the last step
// display data at any time
//
// frame rate
// source / prescale / divider / 2 halves / slots
// software aims near 30 to 100 Hz
// the rate is not checked here

module lcdsd_top
    import lcdsd_pkg::*;
#(
    parameter int SEGS = 32
) (
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             low_speed_crystal,
    input  wire logic             low_speed_rc_osc,
    input  wire logic             power_down,
    input  wire logic [SEGS-1:0]  seg_port_in,
    output logic      [SEGS-1:0]  seg_port_read,
    output logic      [5:0]       com_pin_lcd,
    output logic      [5:0]       com_select,
    output logic      [SEGS-1:0]  seg_pin_lcd,
    output logic      [SEGS-1:0]  seg_dark,
    output logic                  drive_phase,
    output logic                  driver_on,
    output logic                  bias_half,
    output logic      [1:0]       ladder_resistance_sel,
    output logic                  ladder_valid,
    output logic                  panel_supply_trim
);

    typedef struct packed {
        logic                  on;
        logic                  trim;
        logic                  bias;
        logic [1:0]            duty;
        logic [1:0]            ladder;
        logic [1:0]            src;
        logic [2:0]            div;
        logic [4:0]            index;
        logic [SEGS-1:0]       seg_en;
        logic [SEGS-1:0][5:0]  mem;
        logic                  xtal_q;
        logic                  rc_q;
        logic [11:0]           pre;
        logic [4:0]            divcnt;
        logic                  phase;
        logic [2:0]            com_idx;
        logic                  ready;
        logic [31:0]           rdata;
        logic                  err;
        logic [5:0]            com_lcd;
        logic [5:0]            com_sel;
        logic [SEGS-1:0]       seg_lcd;
        logic [SEGS-1:0]       dark;
        logic [SEGS-1:0]       port_rd;
        logic                  ladder_ok;
    } lcdsd_state_t;

    lcdsd_state_t st;
    lcdsd_state_t next_st;

    logic [9:0]      acc_idx;
    logic            acc_done;
    logic [7:0]      wbyte;
    logic [7:0]      rbyte;
    logic            mapped;
    logic            src_tick;
    logic            pre_tick;
    logic            lcd_tick;
    logic [11:0]     pre_last;
    logic [4:0]      div_last;
    logic [2:0]      com_last;
    logic            duty_ok;
    logic [SEGS-1:0] seg_allow;

    // bus decode; the index sits in the word address bits
    assign acc_idx  = paddr[11:2];
    assign acc_done = psel & penable & st.ready;
    assign wbyte    = pwdata[7:0];

    // read mux and unmapped detection
    always_comb begin
        rbyte  = 8'h00;
        mapped = 1'b1;
        if (acc_idx == IDX_SEG_LOW) begin
            rbyte = st.seg_en[7:0];
        end else if (acc_idx == IDX_SEG_MID_LOW) begin
            rbyte = st.seg_en[15:8];
        end else if (acc_idx == IDX_SEG_MID_HIGH) begin
            rbyte = st.seg_en[23:16];
        end else if (acc_idx == IDX_SEG_HIGH) begin
            rbyte = st.seg_en[31:24];
        end else if (acc_idx == IDX_CONTROL) begin
            rbyte = {st.on, st.trim, 1'b0, st.bias, st.duty, st.ladder}; // RULE23
        end else if (acc_idx == IDX_CLOCK_CFG) begin
            rbyte = {2'b00, st.src, 1'b0, st.div}; // RULE23
        end else if (acc_idx == IDX_DATA_INDEX) begin
            rbyte = {3'b000, st.index}; // RULE11
        end else if (acc_idx == IDX_DATA_PORT) begin
            rbyte = {2'b00, st.mem[st.index]}; // RULE12
        end else begin
            mapped = 1'b0;
        end
    end

    // clock source pick and prescale; system clock stops in power-down
    always_comb begin
        src_tick = 1'b0;
        pre_last = SYS_PRE_LAST;
        case (st.src)
            SRC_SYSTEM: begin
                src_tick = ~power_down; // RULE7
            end
            SRC_CRYSTAL: begin
                src_tick = low_speed_crystal & ~st.xtal_q; // RULE8
                pre_last = LS_PRE_LAST;
            end
            SRC_RC: begin
                src_tick = low_speed_rc_osc & ~st.rc_q; // RULE8
                pre_last = LS_PRE_LAST;
            end
            default: begin
                src_tick = 1'b0; // reserved source gives no clock
            end
        endcase
    end

    assign pre_tick = src_tick & (st.pre >= pre_last);
    // divide by 2^code; reserved codes stop the display clock
    assign div_last = 5'((6'h01 << st.div) - 6'h01); // RULE10
    assign lcd_tick = pre_tick & (st.div <= DIV_MAX_CODE) & (st.divcnt >= div_last);

    // number of commons in use per duty
    always_comb begin
        com_last = 3'd3;
        duty_ok  = 1'b1;
        case (st.duty)
            DUTY_QUARTER: com_last = 3'd3;
            DUTY_THIRD:   com_last = 3'd2; // RULE4
            DUTY_SIXTH:   com_last = 3'd5; // RULE5
            default: begin
                duty_ok = 1'b0; // RULE3
            end
        endcase
    end

    // segment pins that may carry lcd waveforms
    always_comb begin
        seg_allow = st.seg_en; // RULE14
        if (st.duty == DUTY_SIXTH) begin
            seg_allow[1:0] = 2'b00; // RULE5
        end
        if (st.src == SRC_CRYSTAL) begin
            seg_allow[SEG_XTAL_A] = 1'b0; // RULE9
            seg_allow[SEG_XTAL_B] = 1'b0; // RULE9
        end
    end

    // next state
    always_comb begin
        next_st = st;

        // apb: one wait state, then ready; write lands on the ready edge
        next_st.ready = psel & penable & ~st.ready;
        next_st.err   = 1'b0; // error stands only with ready
        if (psel & penable & ~st.ready) begin
            next_st.rdata = {24'h00_0000, rbyte};
            next_st.err   = ~mapped;
        end
        if (acc_done & pwrite & mapped) begin
            if (acc_idx == IDX_SEG_LOW) begin
                next_st.seg_en[7:0] = wbyte; // RULE14
            end else if (acc_idx == IDX_SEG_MID_LOW) begin
                next_st.seg_en[15:8] = wbyte;
            end else if (acc_idx == IDX_SEG_MID_HIGH) begin
                next_st.seg_en[23:16] = wbyte;
            end else if (acc_idx == IDX_SEG_HIGH) begin
                next_st.seg_en[31:24] = wbyte;
            end else if (acc_idx == IDX_CONTROL) begin
                next_st.on     = wbyte[CTL_ON_BIT]; // RULE1
                next_st.trim   = wbyte[CTL_TRIM_BIT];
                next_st.bias   = wbyte[CTL_BIAS_BIT]; // RULE2
                next_st.duty   = wbyte[CTL_DUTY_LSB +: 2]; // RULE3
                next_st.ladder = wbyte[CTL_LADDER_LSB +: 2]; // RULE6
            end else if (acc_idx == IDX_CLOCK_CFG) begin
                next_st.src = wbyte[CLK_SRC_LSB +: 2]; // RULE7
                next_st.div = wbyte[CLK_DIV_LSB +: 3]; // RULE10
            end else if (acc_idx == IDX_DATA_INDEX) begin
                next_st.index = wbyte[4:0]; // RULE11
            end else if (acc_idx == IDX_DATA_PORT) begin
                next_st.mem[st.index] = wbyte[5:0]; // RULE12
            end
        end

        // edge detect on the low-speed clocks
        next_st.xtal_q = low_speed_crystal;
        next_st.rc_q   = low_speed_rc_osc;

        // prescaler and divider chain
        if (src_tick) begin
            next_st.pre = pre_tick ? 12'h000 : 12'(st.pre + 12'h001);
        end
        if (pre_tick) begin
            next_st.divcnt = (st.divcnt >= div_last) ? 5'h00 : 5'(st.divcnt + 5'h01);
        end

        // common sequencer; each slot has two halves of opposite polarity
        if (!st.on || !duty_ok) begin
            next_st.phase   = 1'b0;
            next_st.com_idx = 3'd0;
        end else if (lcd_tick) begin
            next_st.phase = ~st.phase;
            if (st.phase) begin
                next_st.com_idx = (st.com_idx >= com_last) ? 3'd0
                                                           : 3'(st.com_idx + 3'd1); // RULE21
            end
        end

        // pin function and drive outputs, registered
        next_st.ladder_ok = (st.ladder != 2'h3); // RULE6
        next_st.com_lcd   = 6'h00;
        next_st.com_sel   = 6'h00;
        next_st.seg_lcd   = '0;
        if (st.on && duty_ok) begin
            for (int c = 0; c < 6; c++) begin
                next_st.com_lcd[c] = (3'(c) <= com_last); // RULE1 RULE4
                next_st.com_sel[c] = (3'(c) == st.com_idx); // RULE21
            end
            next_st.seg_lcd = seg_allow; // RULE1
        end
        for (int s = 0; s < SEGS; s++) begin
            next_st.dark[s] = st.mem[s][st.com_idx]; // RULE12 RULE20
        end

        // port reads of lcd-owned segment pins see zero
        next_st.port_rd = seg_port_in & ~({SEGS{st.on}} & st.seg_en); // RULE15
    end

    // state register
    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign prdata                = st.rdata;
    assign pready                = st.ready;
    assign pslverr               = st.err;
    assign seg_port_read         = st.port_rd;
    assign com_pin_lcd           = st.com_lcd;
    assign com_select            = st.com_sel;
    assign seg_pin_lcd           = st.seg_lcd;
    assign seg_dark              = st.dark;
    assign drive_phase           = st.phase;
    assign driver_on             = st.on;
    assign bias_half             = st.bias; // RULE2
    assign ladder_resistance_sel = st.ladder;
    assign ladder_valid          = st.ladder_ok;
    assign panel_supply_trim     = st.trim;

endmodule : lcdsd_top

// [tb/lcdsd_asserts.sv]
// concurrent checks on the ports of the display driver top
// assumes one clock domain, bound onto every top instance below
`timescale 1ns/1ps
module lcdsd_chk #(
    parameter int SEGS = 32
) (
    input wire logic            mclk,
    input wire logic            srst,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic [SEGS-1:0] seg_port_in,
    input wire logic [SEGS-1:0] seg_port_read,
    input wire logic [5:0]      com_pin_lcd,
    input wire logic [5:0]      com_select,
    input wire logic [SEGS-1:0] seg_pin_lcd,
    input wire logic            driver_on,
    input wire logic [1:0]      ladder_resistance_sel,
    input wire logic            ladder_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // bus answer: one wait state, single pulse, clean lanes
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("bus access not answered");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("refused access bad answer");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("reserved read bits set");
    // pins follow the driver enable, outputs lag state by one cycle
    off_release_a: assert property ((!driver_on) [*2] |-> com_pin_lcd == 6'h00 && seg_pin_lcd == '0)
        else $error("pins driven while off");
    read_plain_a: assert property ((!driver_on) [*2] |-> seg_port_read == $past(seg_port_in))
        else $error("port read masked while off");
    mask_sub_a: assert property (1'b1 |=> (seg_port_read & ~$past(seg_port_in)) == '0)
        else $error("port read shows a bit not at input");
    com_onehot_a: assert property ($onehot0(com_select))
        else $error("two commons active");
    sixth_pins_a: assert property (|com_pin_lcd[5:4] |-> seg_pin_lcd[1:0] == 2'h0)
        else $error("segment 0 or 1 driven as segment");
    ladder_ok_a: assert property (!$past(srst) && $stable(ladder_resistance_sel)
        |-> ladder_valid == (ladder_resistance_sel != 2'h3))
        else $error("ladder valid wrong");
    cover property (pslverr);
    cover property (com_select[5]);
    cover property (!com_pin_lcd[3] && com_select[2]);
endmodule : lcdsd_chk

bind lcdsd_top lcdsd_chk #(.SEGS(SEGS)) u_lcdsd_chk (.mclk, .srst, .psel, .penable, .prdata,
    .pready, .pslverr, .seg_port_in, .seg_port_read, .com_pin_lcd, .com_select, .seg_pin_lcd,
    .driver_on, .ladder_resistance_sel, .ladder_valid);

// [tb/lcdsd_panel.sv]
// behavioural glass: latches dark pixels per common, times common slots
// assumes registered one-hot common select and segment data from the driver
`timescale 1ns/1ps
module lcdsd_panel (
    input wire logic        mclk,
    input wire logic        clr,
    input wire logic [5:0]  com_select,
    input wire logic [31:0] seg_pin_lcd,
    input wire logic [31:0] seg_dark,
    output logic     [5:0]  seen,
    output logic     [31:0] pix [6],
    output int              gap
);
    logic [5:0] prev = 6'h00;
    int         cnt = 0;
    // a pixel only counts once its common has settled for a cycle
    always @(posedge mclk) begin
        prev <= com_select;
        cnt <= (com_select != prev) ? 0 : cnt + 1;
        if (com_select != prev)
            gap <= cnt + 1;
        for (int c = 0; c < 6; c++)
            if (clr)
                pix[c] <= 32'h0000_0000;
            else if (com_select[c] && com_select == prev)
                pix[c] <= seg_dark & seg_pin_lcd;
        seen <= clr ? 6'h00 : seen | (com_select == prev ? com_select : 6'h00);
    end
endmodule : lcdsd_panel

// [tb/tb.sv]
// self-checking bench for the display driver control block
// assumes the checker bind and the glass model on the pin side
`timescale 1ns/1ps
module tb;
    import lcdsd_pkg::*;
    logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, rd_e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, seg_port_in = 32'hffff_ffff, prdata, rd_v;
    logic        low_speed_crystal = 0, low_speed_rc_osc = 0, power_down = 0;
    logic        run_x = 0, run_r = 0, clr = 0, pready, pslverr, drive_phase;
    logic        driver_on, bias_half, ladder_valid, panel_supply_trim;
    logic [1:0]  ladder_resistance_sel;
    logic [5:0]  com_pin_lcd, com_select, seen;
    logic [31:0] seg_port_read, seg_pin_lcd, seg_dark, pix [6];
    int          gap, fails = 0, check_count = 0, cyc = 0;

    lcdsd_top #(.SEGS(32)) u_lcdsd_top (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .low_speed_crystal, .low_speed_rc_osc,
        .power_down, .seg_port_in, .seg_port_read, .com_pin_lcd, .com_select, .seg_pin_lcd,
        .seg_dark, .drive_phase, .driver_on, .bias_half, .ladder_resistance_sel,
        .ladder_valid, .panel_supply_trim);
    lcdsd_panel u_lcdsd_panel (.mclk, .clr, .com_select, .seg_pin_lcd, .seg_dark, .seen,
        .pix, .gap);

    always #10 mclk = ~mclk;
    // slow sources stand still outside frame tests; hang guard
    always @(posedge mclk) begin
        low_speed_crystal <= run_x & ~low_speed_crystal;
        low_speed_rc_osc <= run_r & ~low_speed_rc_osc;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, x, g);
        end
    endtask : chk

    // request held until pready is sampled; idle edge keeps drivers single
    task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) fails++;
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        apb(1, i, d);
    endtask : wr

    task automatic rd(input logic [9:0] i, input logic [7:0] x, input logic xe);
        apb(0, i, 8'h00);
        chk("prdata", {24'h00_0000, x}, rd_v);
        chk("pslverr", xe, rd_e);
    endtask : rd

    function automatic logic [7:0] pat(input int s);
        return 8'((s * 7 + 9) & 63);
    endfunction : pat

    task automatic t_reset();
        logic [9:0] ids [8];
        ids = '{IDX_SEG_LOW, IDX_SEG_MID_LOW, IDX_SEG_MID_HIGH, IDX_SEG_HIGH,
                IDX_CONTROL, IDX_CLOCK_CFG, IDX_DATA_INDEX, IDX_DATA_PORT};
        foreach (ids[k]) rd(ids[k], REG_RESET, 0);
    endtask : t_reset

    // reserved bits, field outputs, unmapped index
    task automatic t_regs();
        wr(IDX_CONTROL, 8'h63);
        rd(IDX_CONTROL, 8'h43, 0);
        chk("trim", 1, panel_supply_trim);
        chk("ladder_valid", 0, ladder_valid);
        wr(IDX_CONTROL, 8'h16);
        rd(IDX_CONTROL, 8'h16, 0);
        chk("bias_half", 1, bias_half);
        chk("ladder", 2, ladder_resistance_sel);
        wr(IDX_CLOCK_CFG, 8'hff);
        rd(IDX_CLOCK_CFG, 8'h37, 0);
        wr(IDX_DATA_INDEX, 8'hff);
        rd(IDX_DATA_INDEX, 8'h1f, 0);
        wr(IDX_DATA_PORT, 8'hff);
        rd(IDX_DATA_PORT, 8'h3f, 0);
        wr(10'h000, 8'h55);
        rd(10'h000, 8'h00, 1);
    endtask : t_regs

    task automatic t_mem();
        for (int s = 0; s < 32; s++) begin
            wr(IDX_DATA_INDEX, 8'(s));
            wr(IDX_DATA_PORT, pat(s));
        end
        for (int s = 31; s >= 0; s--) begin
            wr(IDX_DATA_INDEX, 8'(s));
            rd(IDX_DATA_PORT, pat(s), 0);
        end
    endtask : t_mem

    // partial enables, port read masking, reserved duty
    task automatic t_port();
        wr(IDX_SEG_LOW, 8'h5a);
        wr(IDX_SEG_MID_LOW, 8'ha5);
        wr(IDX_SEG_MID_HIGH, 8'h0f);
        wr(IDX_SEG_HIGH, 8'hf0);
        wr(IDX_CONTROL, 8'h80);
        repeat (3) @(posedge mclk);
        chk("port_read", ~32'hf00f_a55a, seg_port_read);
        chk("seg_pin_lcd", 32'hf00f_a55a, seg_pin_lcd);
        wr(IDX_CONTROL, 8'h00);
        repeat (3) @(posedge mclk);
        chk("port_read", 32'hffff_ffff, seg_port_read);
        wr(IDX_CONTROL, 8'h8c);
        repeat (3) @(posedge mclk);
        chk("com_pin_lcd", 0, com_pin_lcd);
        wr(IDX_CONTROL, 8'h00);
    endtask : t_port

    task automatic t_frame(input logic [1:0] du, input logic [1:0] sr, input logic [2:0] dv,
                           input logic pd, input logic [5:0] xs, input int slot, input int n);
        logic [31:0] xl;
        logic [7:0]  p;
        xl = 32'hffff_ffff;
        if (du == DUTY_SIXTH) xl[1:0] = 2'b00;
        if (sr == SRC_CRYSTAL) xl[30:29] = 2'b00;
        run_x <= (sr == SRC_CRYSTAL);
        run_r <= (sr == SRC_RC);
        power_down <= pd;
        wr(IDX_CLOCK_CFG, {2'b00, sr, 1'b0, dv});
        wr(IDX_CONTROL, {4'h0, du, 2'b00});
        wr(IDX_SEG_LOW, 8'hff);
        wr(IDX_SEG_MID_LOW, 8'hff);
        wr(IDX_SEG_MID_HIGH, 8'hff);
        wr(IDX_SEG_HIGH, 8'hff);
        wr(IDX_CONTROL, {4'h8, du, 2'b00});
        clr <= 1;
        @(posedge mclk);
        clr <= 0;
        repeat (n) @(posedge mclk);
        chk("com_seen", xs, seen);
        chk("slot_len", slot, gap);
        chk("com_pin_lcd", xs, com_pin_lcd);
        chk("seg_pin_lcd", xl, seg_pin_lcd);
        for (int c = 0; c < 6; c++)
            for (int s = 0; s < 32; s++) begin
                p = pat(s);
                if (xs[c]) chk("pixel", xl[s] & p[c], pix[c][s]);
            end
        wr(IDX_CONTROL, 8'h00);
        repeat (2) @(posedge mclk);
        chk("drive_phase", 0, drive_phase);
        chk("com_select", 0, com_select);
        run_x <= 0;
        run_r <= 0;
        power_down <= 0;
    endtask : t_frame

    initial begin
        repeat (8) @(posedge mclk);
        srst <= 0;
        @(posedge mclk);
        t_reset();
        t_regs();
        t_mem();
        t_port();
        t_frame(DUTY_SIXTH, SRC_CRYSTAL, 3'h0, 1, 6'h3f, 64, 600);
        t_frame(DUTY_THIRD, SRC_RC, 3'h5, 1, 6'h07, 2048, 6500);
        t_frame(DUTY_QUARTER, SRC_SYSTEM, 3'h0, 0, 6'h0f, 8192, 34000);
        wrap_up();
    end
endmodule : tb
